/* File: bcx_bus_config.sv */
// Data bus configuration register with extended pin mode logic
`timescale 1ns/10ps
// Functional notes
// RULE_01: Hardware reset clears bits 15 and 13 and keeps all other bits of the register.
// RULE_02: A software reset command leaves the configuration register unchanged.
// RULE_03: The host accesses the configuration register only while soft reset is set.
// RULE_04: Extended mode turns tx data, loopback, rx clock, rx data into user outputs 3..0.
// RULE_05: After hardware reset the four user output pins float until the register is rewritten.
// RULE_06: In extended mode the pins float until bus master, then follow the second register.
// RULE_07: Without extended mode the four pins serve the encoder interface.
// RULE_08: In extended mode tx clock is a termination input, active in async mode and style 1.
// RULE_09: The tx clock pin floats after reset until rewrite, and until bus master in ext mode.
// RULE_10: Without extended mode tx clock is the encoder clock input.
// RULE_11: Extended mode in async mode captures bus retry on the falling clock edge.
// RULE_12: Without extended mode bus retry is sampled on the rising clock edge.
// RULE_13: Hardware reset sets soft reset; the device idles until software clears it.
// RULE_14: Async mode synchronises ready inputs on the falling edge in the second state.
// RULE_15: Software writes zero to reserved bits 14 and 5, which read back as zero.
module bcx_bus_config
   import bcx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire bcx_req_s req,
   output logic [15:0] rdata,
   // Bus state and strobes
   input wire logic bus_master,
   input wire logic bus_style_select_pin,
   input wire logic dma_second_state,
   input wire logic ready_input,
   input wire logic [1:0] transfer_acknowledge_inputs,
   input wire logic bus_retry_input,
   // Encoder side outputs from the internal encoder
   input wire logic enc_tx_data,
   input wire logic enc_loopback,
   input wire logic enc_rx_clock_out,
   input wire logic enc_rx_data_out,
   input wire logic enc_pins_drive,
   // Repurposable pins: 3 tx data, 2 loopback, 1 rx clock, 0 rx data
   input wire logic [3:0] enc_pins_in,
   output bcx_pins_s enc_pins,
   // Transmit clock pin
   input wire logic encoder_tx_clock_pin,
   output logic enc_tx_clock,
   output logic sync_memory_termination,
   // Results
   output logic bus_retry_seen,
   output logic ready_seen,
   output logic device_operational,
   output logic [15:0] data_bus_configuration,
   output logic [15:0] second_bus_configuration
);

   // Reset release through two flops
   logic rst_s1_q;
   logic rst_s2_q;
   logic hw_rst_d1_q;
   logic [15:0] dbc_q;
   logic [15:0] dbc_d;
   logic [15:0] dbc2_q;
   logic [15:0] dbc2_d;
   logic [15:0] cmd_q;
   logic [15:0] cmd_d;
   logic rewritten_q;
   logic rewritten_d;
   logic retry_rise_q;
   logic retry_fall_q;
   logic ready_fall_q;
   logic ready_rise_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   wire logic rst_int_n = rst_s2_q;

   // Decode
   wire logic soft_reset = cmd_q[BCX_BIT_SOFT_RESET];
   wire logic ext_mode = dbc_q[BCX_BIT_EXT_ENABLE];
   wire logic async_mode = ~dbc_q[BCX_BIT_SYNC_READY];
   wire logic sel_cmd = req.addr == BCX_IDX_COMMAND;
   wire logic sel_dbc = req.addr == BCX_IDX_DATA_BUS_CONFIG;
   wire logic sel_dbc2 = req.addr == BCX_IDX_SECOND_BUS_CONFIG;
   wire logic wr_dbc = req.wr & sel_dbc & soft_reset; // RULE_03
   wire logic rd_dbc = sel_dbc & soft_reset; // RULE_03
   wire logic pins_live = rewritten_q & ext_mode & bus_master; // RULE_05 RULE_06 RULE_09
   wire logic enc_normal = ~ext_mode; // RULE_07 RULE_10

   // Next values of the registers
   always_comb begin
      dbc_d = dbc_q;
      dbc2_d = dbc2_q;
      cmd_d = cmd_q;
      rewritten_d = rewritten_q;
      if (wr_dbc) begin
         dbc_d = req.wdata & BCX_RSVD_MASK; // RULE_15
         rewritten_d = 1'b1;
      end
      if (req.wr && sel_dbc2) begin
         dbc2_d = req.wdata;
      end
      if (req.wr && sel_cmd) begin
         cmd_d = req.wdata; // RULE_02 RULE_13
      end
   end

   // Read mux
   assign rdata_d = !req.rd ? BCX_ZERO16 :
                    rd_dbc ? dbc_q :
                    sel_dbc2 ? dbc2_q :
                    sel_cmd ? cmd_q : BCX_ZERO16;

   // Hardware reset marker, one cycle after release
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hw_rst_d1_q <= 1'b1;
      end else begin
         hw_rst_d1_q <= ~rst_int_n;
      end
   end

   // Configuration keeps its bits through reset except 15 and 13
   always_ff @(posedge ref_clk) begin
      if (hw_rst_d1_q) begin
         dbc_q <= dbc_q & BCX_HWRST_CLEAR_MASK; // RULE_01
      end else begin
         dbc_q <= dbc_d;
      end
   end

   // Control registers with defined reset
   always_ff @(posedge ref_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cmd_q <= BCX_CMD_RESET_VAL; // RULE_13
         dbc2_q <= BCX_ZERO16;
         rewritten_q <= 1'b0; // RULE_05
         rdata_q <= BCX_ZERO16;
      end else begin
         cmd_q <= cmd_d;
         dbc2_q <= dbc2_d;
         rewritten_q <= rewritten_d;
         rdata_q <= rdata_d;
      end
   end

   // Bus retry sampled on both edges
   always_ff @(posedge ref_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         retry_rise_q <= 1'b0;
         ready_rise_q <= 1'b0;
      end else begin
         retry_rise_q <= bus_retry_input; // RULE_12
         ready_rise_q <= bus_style_select_pin ? |transfer_acknowledge_inputs : ready_input;
      end
   end

   always_ff @(negedge ref_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         retry_fall_q <= 1'b0;
         ready_fall_q <= 1'b0;
      end else begin
         retry_fall_q <= bus_retry_input; // RULE_11
         if (dma_second_state) begin
            ready_fall_q <= bus_style_select_pin ? |transfer_acknowledge_inputs
                                                 : ready_input; // RULE_14
         end
      end
   end

   assign bus_retry_seen = (ext_mode & async_mode) ? retry_fall_q : retry_rise_q; // RULE_11 RULE_12
   assign ready_seen = async_mode ? ready_fall_q : ready_rise_q; // RULE_14

   // Pin drivers for the four repurposable pins
   assign enc_pins.val = pins_live ? dbc2_q[BCX_EXTRA_USER_OUTPUTS_HI:BCX_EXTRA_USER_OUTPUTS_LO] // RULE_04
                       : {enc_tx_data, enc_loopback, enc_rx_clock_out, enc_rx_data_out};
   assign enc_pins.oe = pins_live ? 4'hF
                      : ((enc_normal & rewritten_q & enc_pins_drive) ? 4'hF : 4'h0); // RULE_07

   // Transmit clock pin roles
   assign enc_tx_clock = (enc_normal & rewritten_q) ? encoder_tx_clock_pin : 1'b0; // RULE_10
   assign sync_memory_termination = pins_live & async_mode
                                  & (bus_style_select_pin == BCX_BUS_STYLE_ACK)
                                  & encoder_tx_clock_pin; // RULE_08 RULE_09

   // Status outputs
   assign device_operational = ~soft_reset; // RULE_13
   assign rdata = rdata_q;
   assign data_bus_configuration = dbc_q;
   assign second_bus_configuration = dbc2_q;

endmodule // bcx_bus_config

/* File: bcx_pkg.sv */
// Package for the bus configuration and extended pin mode block
package bcx_pkg;
   // Register indices on the plain register port
   localparam logic [5:0] BCX_IDX_COMMAND = 6'h00;
   localparam logic [5:0] BCX_IDX_DATA_BUS_CONFIG = 6'h01;
   localparam logic [5:0] BCX_IDX_SECOND_BUS_CONFIG = 6'h3F;
   // Field positions in the data bus configuration register
   localparam int BCX_BIT_EXT_ENABLE = 15;
   localparam int BCX_BIT_RSVD_HI = 14;
   localparam int BCX_BIT_LATCHED_RETRY = 13;
   localparam int BCX_BIT_SYNC_READY = 10;
   localparam int BCX_BIT_RSVD_LO = 5;
   // Command register soft reset bit
   localparam int BCX_BIT_SOFT_RESET = 7;
   // Second configuration: extra user output levels, bits 15..12
   localparam int BCX_EXTRA_USER_OUTPUTS_HI = 15;
   localparam int BCX_EXTRA_USER_OUTPUTS_LO = 12;
   // Masks
   localparam logic [15:0] BCX_HWRST_CLEAR_MASK = 16'h5FFF;
   localparam logic [15:0] BCX_RSVD_MASK = 16'hBFDF;
   localparam logic [15:0] BCX_ZERO16 = 16'h0000;
   localparam logic [15:0] BCX_CMD_RESET_VAL = 16'h0080;
   // Bus style pin value for the acknowledge style bus
   localparam logic BCX_BUS_STYLE_ACK = 1'b1;

   // Register port request
   typedef struct packed {
      logic [5:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bcx_req_s;

   // Encoder pin group, outputs with enables
   typedef struct packed {
      logic [3:0] val;
      logic [3:0] oe;
   } bcx_pins_s;
endpackage

/* File: bcx_checker.sv */
// Assertion checker for the bus configuration block
`timescale 1ns/10ps
module bcx_checker
   import bcx_pkg::*;
(
   // Clock, reset and register port
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire bcx_req_s req,
   input wire logic [15:0] rdata,
   // Pins and state
   input wire logic bus_master,
   input wire logic bus_style_select_pin,
   input wire logic encoder_tx_clock_pin,
   input wire bcx_pins_s enc_pins,
   input wire logic sync_memory_termination,
   input wire logic device_operational,
   input wire logic [15:0] data_bus_configuration,
   input wire logic [15:0] second_bus_configuration
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Decoded requests and mode
   wire ext = data_bus_configuration[BCX_BIT_EXT_ENABLE];
   sequence s_cfg_wr; req.wr && req.addr == BCX_IDX_DATA_BUS_CONFIG; endsequence
   sequence s_cfg_rd; req.rd && req.addr == BCX_IDX_DATA_BUS_CONFIG; endsequence
   sequence s_cmd_wr; req.wr && req.addr == BCX_IDX_COMMAND; endsequence
   property p_drv; ext && bus_master |-> enc_pins == {second_bus_configuration[15:12], 4'hF};
   endproperty
   a_drv: assert property (p_drv) else $error("user outputs");
   property p_flt; ext && !bus_master |-> enc_pins.oe == 4'h0; endproperty
   a_flt: assert property (p_flt) else $error("float");
   property p_trm; ext && !data_bus_configuration[10] && bus_style_select_pin && bus_master
      |-> sync_memory_termination == encoder_tx_clock_pin; endproperty
   a_trm: assert property (p_trm) else $error("termination");
   property p_cmd; s_cmd_wr |=> device_operational == !$past(req.wdata[7]); endproperty
   a_cmd: assert property (p_cmd) else $error("soft reset");
   property p_keep; s_cmd_wr |=> $stable(data_bus_configuration); endproperty
   a_keep: assert property (p_keep) else $error("keep");
   property p_lock; s_cfg_wr ##0 device_operational |=> $stable(data_bus_configuration);
   endproperty
   a_lock: assert property (p_lock) else $error("lock");
   property p_msk; s_cfg_wr ##0 !device_operational
      |=> data_bus_configuration == ($past(req.wdata) & BCX_RSVD_MASK); endproperty
   a_msk: assert property (p_msk) else $error("mask");
   property p_rd; s_cfg_rd ##0 !device_operational |=> rdata == $past(data_bus_configuration);
   endproperty
   a_rd: assert property (p_rd) else $error("read");
endmodule // bcx_checker
bind bcx_bus_config bcx_checker u_chk (.ref_clk, .rst_n, .req, .rdata, .bus_master,
   .bus_style_select_pin, .encoder_tx_clock_pin, .enc_pins, .sync_memory_termination,
   .device_operational, .data_bus_configuration, .second_bus_configuration);

/* File: bcx_host.sv */
// Host model issuing register port cycles
`timescale 1ns/10ps
module bcx_host
   import bcx_pkg::*;
(
   // Clock and register port
   input wire logic ref_clk,
   output bcx_req_s req,
   input wire logic [15:0] rdata
);
   initial req = '0;
   // Write cycle, one strobe cycle
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask
   // Read cycle, data taken in the following cycle
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
endmodule // bcx_host

/* File: testbench.sv */
// Self-checking testbench for the bus configuration block
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench import bcx_pkg::*; ();
   logic ref_clk = 0, rst_n = 0, bus_master = 0, bus_style_select_pin = 1;
   logic encoder_tx_clock_pin = 0, enc_pins_drive = 0;
   logic retry = 0, retry_seen;
   logic [3:0] src = 4'h5;
   logic [15:0] d, rdata, data_bus_configuration, second_bus_configuration;
   bcx_req_s req;
   bcx_pins_s enc_pins;
   logic enc_tx_clock, sync_memory_termination, device_operational;
   int failures = 0, check_count = 0;
   initial forever #2 ref_clk = ~ref_clk;
   bcx_host host (.ref_clk, .req, .rdata);
   bcx_bus_config DUT (.ref_clk, .rst_n, .req, .rdata, .bus_master, .bus_style_select_pin,
      .dma_second_state(1'b0), .ready_input(1'b0), .transfer_acknowledge_inputs(2'h0),
      .bus_retry_input(retry), .enc_tx_data(src[3]), .enc_loopback(src[2]),
      .enc_rx_clock_out(src[1]), .enc_rx_data_out(src[0]), .enc_pins_drive,
      .enc_pins_in(4'h0), .enc_pins, .encoder_tx_clock_pin, .enc_tx_clock,
      .sync_memory_termination, .bus_retry_seen(retry_seen), .ready_seen(), .device_operational,
      .data_bus_configuration, .second_bus_configuration);
   // Report and end the run
   task automatic print_verdict();
      $display("failures=%0d check_count=%0d", failures, check_count);
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      host.wr(BCX_IDX_DATA_BUS_CONFIG, 16'hFFFF);
      host.rd(BCX_IDX_DATA_BUS_CONFIG, d);
      `CHK(d, 16'hBFDF)
      `CHK(enc_pins.oe, 4'h0)
      host.wr(BCX_IDX_SECOND_BUS_CONFIG, 16'hA000);
      bus_master <= 1'b1;
      @(posedge ref_clk) #1 `CHK(enc_pins, 8'hAF)
      host.wr(BCX_IDX_DATA_BUS_CONFIG, 16'h80FF);
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk) encoder_tx_clock_pin <= i[0];
         @(posedge ref_clk) #1 `CHK(sync_memory_termination, i[0])
      end
      @(posedge ref_clk) retry <= 1'b1;
      @(negedge ref_clk) #1 `CHK(retry_seen, 1'b1)
      @(posedge ref_clk) retry <= 1'b0;
      host.wr(BCX_IDX_COMMAND, 16'h0000);
      host.wr(BCX_IDX_DATA_BUS_CONFIG, 16'h1234);
      host.rd(BCX_IDX_DATA_BUS_CONFIG, d);
      `CHK(d, 16'h0000)
      host.wr(BCX_IDX_COMMAND, BCX_CMD_RESET_VAL);
      host.rd(BCX_IDX_DATA_BUS_CONFIG, d);
      `CHK(d, 16'h80DF)
      enc_pins_drive <= 1'b1;
      @(posedge ref_clk) rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK(enc_pins.oe, 4'h0)
      `CHK(device_operational, 1'b0)
      host.rd(BCX_IDX_DATA_BUS_CONFIG, d);
      `CHK(d, 16'h80DF & BCX_HWRST_CLEAR_MASK)
      host.wr(BCX_IDX_DATA_BUS_CONFIG, 16'h00FF);
      @(posedge ref_clk) #1 `CHK(enc_pins, {src, 4'hF})
      `CHK(enc_tx_clock, encoder_tx_clock_pin)
      @(posedge ref_clk) retry <= 1'b1;
      @(negedge ref_clk) #1 `CHK(retry_seen, 1'b0)
      @(posedge ref_clk) #1 `CHK(retry_seen, 1'b1)
      print_verdict();
   end
endmodule // testbench
